// ### aapf_defs.vh
`ifndef AAPF_DEFS_VH
`define AAPF_DEFS_VH

// Register offsets on the plain register port
`define AAPF_OFS_SAMPLE 8'h0c
`define AAPF_OFS_THRESH 8'h0d
`define AAPF_OFS_STATUS 8'h0e
`define AAPF_OFS_DATA 8'h0f
`define AAPF_OFS_ROUTE 8'h10

// Sample interval control fields
`define AAPF_SMP_TIMED_BIT 7
`define AAPF_SMP_CODE_MSB 6
`define AAPF_SMP_DEC_LSB 4
`define AAPF_SMP_MUL_MSB 3

// Threshold and width fields
`define AAPF_THR_WIDE_BIT 7
`define AAPF_THR_MSB 4

// State and control bits
`define AAPF_ST_RESET_BIT 0
`define AAPF_ST_FULL_BIT 1
`define AAPF_ST_THR_BIT 2
`define AAPF_ST_EMPTY_BIT 3
`define AAPF_ST_SLOW_BIT 4
`define AAPF_ST_PAUSE_BIT 5
`define AAPF_ST_OVR_BIT 6

// Interrupt routing fields
`define AAPF_RT_A_BIT 0
`define AAPF_RT_B_BIT 1
`define AAPF_RT_EXT_BIT 2
`define AAPF_RT_PIN_LSB 3
`define AAPF_RT_PIN_MSB 5
`define AAPF_RT_MASK_BIT 6

// Reset values
`define AAPF_SMP_RESET 8'h00
`define AAPF_THR_RESET 8'h1f
`define AAPF_RT_RESET 8'h00

// FIFO geometry
`define AAPF_DEPTH 6'd32
`define AAPF_PAIR_ROOM 6'd30

// Timing
`define AAPF_CLK_MHZ 50
`define AAPF_FAST_NS 200
`define AAPF_SLOW_NS 400
`define AAPF_NS_PER_US 1000
`define AAPF_MAX_DECADE 3'd4
`define AAPF_MAX_MULT 4'd9

`endif

// ### aapf_core.v
`timescale 1ns/100ps
`include "aapf_defs.vh"

module aapf_core #(
    parameter CYCLES_PER_US = `AAPF_CLK_MHZ // Shorten for simulation
) (
    input wire mclk,
    input wire reset,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire [7:0] adc_data,
    input wire adc_eoc,
    output reg start_conv,
    output reg low_byte_strobe,
    output reg high_byte_strobe,
    output reg cpu_irq_input_a,
    output reg cpu_irq_input_b,
    output reg [7:0] external_irq_output
);

    // Pulse widths in cycles, least times rounded up
    localparam integer FAST_NUM =
        (`AAPF_FAST_NS * `AAPF_CLK_MHZ + `AAPF_NS_PER_US - 1)
        / `AAPF_NS_PER_US;
    localparam integer SLOW_NUM =
        (`AAPF_SLOW_NS * `AAPF_CLK_MHZ + `AAPF_NS_PER_US - 1)
        / `AAPF_NS_PER_US;
    // Cut to counter width on purpose; both counts fit five bits
    localparam [4:0] FAST_CYC = FAST_NUM[4:0];
    localparam [4:0] SLOW_CYC = SLOW_NUM[4:0];
    // Wide enough for the longest interval at the full clock
    localparam integer US_NUM = CYCLES_PER_US;
    localparam [22:0] US_CYC = US_NUM[22:0];

    // Sampler states
    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_START = 3'd1;
    localparam [2:0] ST_CONV = 3'd2;
    localparam [2:0] ST_LOW = 3'd3;
    localparam [2:0] ST_HIGH = 3'd4;
    localparam [2:0] ST_STORE = 3'd5;

    // Software-visible control state
    reg [7:0] sample_interval_control; // Timed bit and interval code
    reg [7:0] fifo_threshold_width; // Width bit and threshold field
    reg fifo_hold_reset; // Holds FIFO and sampler in reset
    reg slow_mode; // Wide strobes when set
    reg pause_sampling; // Stops at sample boundary
    reg [7:0] acquisition_irq_routing; // Destination and mask

    // Sampler state
    reg [2:0] state;
    reg [4:0] pulse_cnt; // Cycles into the current strobe
    reg [22:0] interval_cnt; // Cycles until next timed start
    reg [7:0] low_hold; // Low byte waiting for its partner
    reg [7:0] high_hold; // High byte of a wide sample

    // FIFO storage and pointers
    reg [7:0] fifo_mem [0:31];
    reg [4:0] wr_ptr;
    reg [4:0] rd_ptr;
    reg [5:0] fill; // Bytes held, 0 to 32
    reg overrun_flag;

    // Interrupt state
    reg threshold_prev; // For edge detection
    reg irq_latch; // Sticky acquisition interrupt

    // Decoded controls
    wire timed = sample_interval_control[`AAPF_SMP_TIMED_BIT];
    wire wide = fifo_threshold_width[`AAPF_THR_WIDE_BIT];
    wire [4:0] thr_field = fifo_threshold_width[`AAPF_THR_MSB:0];
    wire [4:0] pulse_last = slow_mode ? SLOW_CYC - 5'd1
                                      : FAST_CYC - 5'd1;
    wire pulse_done = (pulse_cnt == pulse_last);

    // FIFO status terms
    wire fifo_full_flag = (fill == `AAPF_DEPTH);
    wire fifo_empty_flag = (fill == 6'd0);
    wire threshold_flag = (fill > {1'b0, thr_field});
    wire store_go = (state == ST_STORE);
    // A pair needs two free slots so both bytes land together
    wire room = wide ? (fill <= `AAPF_PAIR_ROOM)
                     : (fill < `AAPF_DEPTH);
    wire push = store_go && room;
    wire [5:0] push_n = wide ? 6'd2 : 6'd1;
    wire data_rd = reg_rd && (reg_addr == `AAPF_OFS_DATA);
    wire data_wr = reg_wr && (reg_addr == `AAPF_OFS_DATA);
    wire pop = data_rd && !fifo_empty_flag;
    wire irq_live = irq_latch &&
        !acquisition_irq_routing[`AAPF_RT_MASK_BIT];

    // Interval code to microseconds: multiplier plus one, times decade
    function [16:0] aapf_interval_us;
        input [6:0] code;
        reg [2:0] dec;
        reg [3:0] mul;
        reg [16:0] val;
        integer i;
        begin
            dec = code[`AAPF_SMP_CODE_MSB:`AAPF_SMP_DEC_LSB];
            mul = code[`AAPF_SMP_MUL_MSB:0];
            // Out-of-table codes clamp rather than wrap
            if (dec > `AAPF_MAX_DECADE) begin
                dec = `AAPF_MAX_DECADE;
            end
            if (mul > `AAPF_MAX_MULT) begin
                mul = `AAPF_MAX_MULT;
            end
            val = {13'h0000, mul} + 17'h00001;
            // Fixed trip count keeps the multiplier chain static
            for (i = 0; i < `AAPF_MAX_DECADE; i = i + 1) begin
                if (i < dec) begin
                    val = val * 17'd10;
                end
            end
            aapf_interval_us = val;
        end
    endfunction

    // Cycles for one whole interval, reloaded at each start
    // A zero rate parameter would wrap the reload; keep it above zero
    wire [39:0] interval_full =
        aapf_interval_us(sample_interval_control[`AAPF_SMP_CODE_MSB:0])
        * US_CYC;
    wire [22:0] interval_load = interval_full[22:0] - 23'd1;

    // Register writes; the data register stores nothing
    always @(posedge mclk) begin
        if (reset) begin
            sample_interval_control <= `AAPF_SMP_RESET;
            fifo_threshold_width <= `AAPF_THR_RESET;
            fifo_hold_reset <= 1'b1;
            slow_mode <= 1'b0;
            pause_sampling <= 1'b1;
            acquisition_irq_routing <= `AAPF_RT_RESET;
        end else if (reg_wr) begin
            case (reg_addr)
                `AAPF_OFS_SAMPLE: begin
                    sample_interval_control <= reg_wdata;
                end
                `AAPF_OFS_THRESH: begin
                    // Unused middle bits read back as zero
                    fifo_threshold_width <= {
                        reg_wdata[`AAPF_THR_WIDE_BIT], 2'b00,
                        reg_wdata[`AAPF_THR_MSB:0]};
                end
                `AAPF_OFS_STATUS: begin
                    // Only the three control bits are writable
                    fifo_hold_reset <= reg_wdata[`AAPF_ST_RESET_BIT];
                    slow_mode <= reg_wdata[`AAPF_ST_SLOW_BIT];
                    pause_sampling <= reg_wdata[`AAPF_ST_PAUSE_BIT];
                end
                `AAPF_OFS_ROUTE: begin
                    // Top bit is reserved and always reads as zero
                    acquisition_irq_routing <= {1'b0,
                        reg_wdata[`AAPF_RT_MASK_BIT:0]};
                end
                default: begin
                    // Unmapped writes and data writes store nothing
                end
            endcase
        end
    end

    // Converter handshake sequencer
    always @(posedge mclk) begin
        if (reset || fifo_hold_reset) begin
            state <= ST_IDLE;
            pulse_cnt <= 5'd0;
            interval_cnt <= 23'd0;
            start_conv <= 1'b0;
            low_byte_strobe <= 1'b0;
            high_byte_strobe <= 1'b0;
            low_hold <= 8'h00;
            high_hold <= 8'h00;
        end else begin
            // Interval timer runs through the whole sample
            if (interval_cnt != 23'd0) begin
                interval_cnt <= interval_cnt - 23'd1;
            end
            case (state)
                ST_IDLE: begin
                    // Pause is only honoured between samples
                    if (!pause_sampling &&
                        (!timed || interval_cnt == 23'd0)) begin
                        state <= ST_START;
                        start_conv <= 1'b1;
                        pulse_cnt <= 5'd0;
                        interval_cnt <= interval_load;
                    end
                end
                ST_START: begin
                    if (pulse_done) begin
                        start_conv <= 1'b0;
                        state <= ST_CONV;
                    end else begin
                        pulse_cnt <= pulse_cnt + 5'd1;
                    end
                end
                ST_CONV: begin
                    // Converter signals completion by a high level
                    // A converter that never answers stalls the port here
                    if (adc_eoc) begin
                        low_byte_strobe <= 1'b1;
                        pulse_cnt <= 5'd0;
                        state <= ST_LOW;
                    end
                end
                ST_LOW: begin
                    if (pulse_done) begin
                        // Byte is taken at the close of its strobe
                        low_hold <= adc_data;
                        low_byte_strobe <= 1'b0;
                        pulse_cnt <= 5'd0;
                        if (wide) begin
                            high_byte_strobe <= 1'b1;
                            state <= ST_HIGH;
                        end else begin
                            state <= ST_STORE;
                        end
                    end else begin
                        pulse_cnt <= pulse_cnt + 5'd1;
                    end
                end
                ST_HIGH: begin
                    if (pulse_done) begin
                        high_hold <= adc_data;
                        high_byte_strobe <= 1'b0;
                        state <= ST_STORE;
                    end else begin
                        pulse_cnt <= pulse_cnt + 5'd1;
                    end
                end
                ST_STORE: begin
                    // One cycle for the FIFO to take the sample
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // FIFO storage; no reset needed, pointers guard validity
    always @(posedge mclk) begin
        if (push) begin
            fifo_mem[wr_ptr] <= low_hold;
            if (wide) begin
                fifo_mem[wr_ptr + 5'd1] <= high_hold;
            end
        end
    end

    // Pointers, fill level and overrun
    always @(posedge mclk) begin
        if (reset || fifo_hold_reset) begin
            wr_ptr <= 5'd0;
            rd_ptr <= 5'd0;
            fill <= 6'd0;
            overrun_flag <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + push_n[4:0];
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 5'd1;
            end
            // Room is judged before a same-cycle read, so it is safe
            fill <= fill + (push ? push_n : 6'd0)
                         - (pop ? 6'd1 : 6'd0);
            // A dropped sample wins over a clearing read
            if (store_go && !room) begin
                overrun_flag <= 1'b1;
            end else if (pop) begin
                overrun_flag <= 1'b0;
            end
        end
    end

    // Read data, valid the cycle after the strobe only
    always @(posedge mclk) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `AAPF_OFS_SAMPLE: begin
                    reg_rdata <= sample_interval_control;
                end
                `AAPF_OFS_THRESH: begin
                    reg_rdata <= fifo_threshold_width;
                end
                `AAPF_OFS_STATUS: begin
                    reg_rdata <= {1'b0, overrun_flag, pause_sampling,
                                  slow_mode, fifo_empty_flag,
                                  threshold_flag, fifo_full_flag,
                                  fifo_hold_reset};
                end
                `AAPF_OFS_DATA: begin
                    // Reading an empty FIFO gives zero, no pop
                    reg_rdata <= fifo_empty_flag ? 8'h00
                                                 : fifo_mem[rd_ptr];
                end
                `AAPF_OFS_ROUTE: begin
                    reg_rdata <= acquisition_irq_routing;
                end
                default: begin
                    reg_rdata <= 8'h00;
                end
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // Sticky interrupt latch; a new edge beats a clearing write
    always @(posedge mclk) begin
        if (reset) begin
            threshold_prev <= 1'b0;
            irq_latch <= 1'b0;
        end else begin
            threshold_prev <= threshold_flag;
            if (threshold_flag && !threshold_prev) begin
                irq_latch <= 1'b1;
            end else if (data_wr) begin
                irq_latch <= 1'b0;
            end
        end
    end

    // Routed interrupt outputs, registered for clean edges
    always @(posedge mclk) begin
        if (reset) begin
            cpu_irq_input_a <= 1'b0;
            cpu_irq_input_b <= 1'b0;
            external_irq_output <= 8'h00;
        end else begin
            cpu_irq_input_a <= irq_live &&
                acquisition_irq_routing[`AAPF_RT_A_BIT];
            cpu_irq_input_b <= irq_live &&
                acquisition_irq_routing[`AAPF_RT_B_BIT];
            // One port pin at a time carries the external copy
            if (irq_live && acquisition_irq_routing[`AAPF_RT_EXT_BIT]) begin
                external_irq_output <= 8'h01 << acquisition_irq_routing[
                    `AAPF_RT_PIN_MSB:`AAPF_RT_PIN_LSB];
            end else begin
                external_irq_output <= 8'h00;
            end
        end
    end

endmodule // aapf_core

// ### aapf_core_checker.sv
`timescale 1ns/100ps
// Port-side checker for the acquisition core
module aapf_chk (
    input wire mclk,
    input wire reset,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire start_conv,
    input wire low_byte_strobe,
    input wire high_byte_strobe,
    input wire cpu_irq_input_a,
    input wire [7:0] external_irq_output
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    logic wide, timed, hold, pause, slow; // Control shadows
    logic [7:0] rt; // Routing shadow
    logic [4:0] n0, n1, n2; // High-run length of each strobe
    wire [4:0] w = slow ? 5'd20 : 5'd10; // Expected strobe width
    wire dw = reg_wr && reg_addr == 8'h0f; // Data register write
    // Shadow writes so rules can see the programmed mode
    always @(posedge mclk) begin
        if (reset) begin
            {wide, timed, hold, pause, slow} <= 5'b00110;
            rt <= 8'h00;
        end else if (reg_wr) begin
            if (reg_addr == 8'h0d)
                wide <= reg_wdata[7];
            if (reg_addr == 8'h0c)
                timed <= reg_wdata[7];
            if (reg_addr == 8'h0e)
                {pause, slow, hold} <= {reg_wdata[5:4], reg_wdata[0]};
            if (reg_addr == 8'h10)
                rt <= reg_wdata;
        end
    end
    // Outputs are low in reset, so the runs start from zero
    always @(posedge mclk) begin
        n0 <= start_conv ? n0 + 5'd1 : 5'd0;
        n1 <= low_byte_strobe ? n1 + 5'd1 : 5'd0;
        n2 <= high_byte_strobe ? n2 + 5'd1 : 5'd0;
    end
    sequence s_hi_go;
        high_byte_strobe ##1 high_byte_strobe;
    endsequence
    property p_sc_w;
        $fell(start_conv) |-> n0 == w;
    endproperty
    property p_lo_w;
        $fell(low_byte_strobe) |-> n1 == w;
    endproperty
    property p_hi_w;
        $fell(high_byte_strobe) |-> n2 == w;
    endproperty
    property p_follow;
        wide && $fell(low_byte_strobe) |-> s_hi_go;
    endproperty
    property p_rd0;
        !$past(reg_rd) |-> reg_rdata == 8'h00;
    endproperty
    property p_hold;
        hold && $past(hold) |-> !start_conv;
    endproperty
    property p_pause;
        pause && $past(pause) |-> !$rose(start_conv);
    endproperty
    property p_max;
        !timed && !pause && !hold
            && $fell(wide ? high_byte_strobe : low_byte_strobe)
            |-> ##[1:3] (start_conv || pause);
    endproperty
    property p_irq_a;
        cpu_irq_input_a |-> $past(rt[0]) && !$past(rt[6]);
    endproperty
    property p_ext;
        |external_irq_output |-> $past(rt[2]) && !$past(rt[6])
            && external_irq_output == 8'h01 << $past(rt[5:3]);
    endproperty
    property p_keep;
        $fell(cpu_irq_input_a) |-> $past(dw, 2) || !$past(rt[0])
            || $past(rt[6]);
    endproperty
    a_sc_w: assert property (p_sc_w) else $error("start width");
    a_lo_w: assert property (p_lo_w) else $error("low width");
    a_hi_w: assert property (p_hi_w) else $error("high width");
    a_follow: assert property (p_follow) else $error("no high");
    a_rd0: assert property (p_rd0) else $error("stray rdata");
    a_hold: assert property (p_hold) else $error("start in hold");
    a_pause: assert property (p_pause) else $error("start paused");
    a_max: assert property (p_max) else $error("no restart");
    a_irq_a: assert property (p_irq_a) else $error("irq a");
    a_ext: assert property (p_ext) else $error("ext irq");
    a_keep: assert property (p_keep) else $error("irq dropped");
endmodule // aapf_chk
bind aapf_core aapf_chk aapf_chk_i (.mclk(mclk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .start_conv(start_conv),
    .low_byte_strobe(low_byte_strobe), .high_byte_strobe(high_byte_strobe),
    .cpu_irq_input_a(cpu_irq_input_a),
    .external_irq_output(external_irq_output));

// ### aapf_adc_model.sv
`timescale 1ns/100ps
// Behavioural converter facing the acquisition port
module aapf_adc_model (
    input wire mclk,
    input wire reset,
    input wire start_conv,
    input wire low_byte_strobe,
    input wire high_byte_strobe,
    input wire [3:0] dly,
    output logic adc_eoc,
    output logic [7:0] adc_data,
    output logic [7:0] cnt
);
    logic [3:0] t; // Conversion time left
    logic busy; // Conversion under way
    logic lo_q, hi_q; // Strobe history
    logic [7:0] last; // Last byte driven
    wire en = low_byte_strobe || high_byte_strobe;
    // Released bus shows the inverse, so stale bytes cannot pass
    assign adc_data = en ? cnt * 8'h3b + 8'h05 : ~last;
    // Byte count advances on each strobe end; delay set per sample
    always @(posedge mclk) begin
        lo_q <= low_byte_strobe;
        hi_q <= high_byte_strobe;
        if (en)
            last <= adc_data;
        if ((lo_q && !low_byte_strobe) || (hi_q && !high_byte_strobe))
            cnt <= cnt + 8'h01;
        if (start_conv) begin
            adc_eoc <= 1'b0;
            busy <= 1'b1;
            t <= dly;
        end else if (busy && t != 4'h0)
            t <= t - 4'h1;
        else if (busy) begin
            adc_eoc <= 1'b1;
            busy <= 1'b0;
        end
        if (reset) begin
            {cnt, adc_eoc, busy, lo_q, hi_q} <= 12'h000;
            last <= 8'ha5;
        end
    end
endmodule // aapf_adc_model

// ### tb.sv
`timescale 1ns/100ps
module tb;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [3:0] dly = 4'h3; // Converter delay, redrawn per sample
    wire [7:0] reg_rdata, adc_data, external_irq_output, pcnt;
    wire adc_eoc, start_conv, low_byte_strobe, high_byte_strobe;
    wire cpu_irq_input_a, cpu_irq_input_b;
    integer seed = 32'hd13f;
    integer errors = 0;
    integer cmp_count = 0;
    integer cyc = 0, nrise = 0, t1 = 0, t2 = 0, i, n;
    logic sc_q = 1'b0;
    logic [7:0] v, b, m, tr;
    always #10 mclk = ~mclk;
    aapf_core #(.CYCLES_PER_US(10)) aapf_core_i (.mclk(mclk),
        .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .adc_data(adc_data), .adc_eoc(adc_eoc), .start_conv(start_conv),
        .low_byte_strobe(low_byte_strobe),
        .high_byte_strobe(high_byte_strobe),
        .cpu_irq_input_a(cpu_irq_input_a),
        .cpu_irq_input_b(cpu_irq_input_b),
        .external_irq_output(external_irq_output));
    aapf_adc_model aapf_adc_model_i (.mclk(mclk), .reset(reset),
        .start_conv(start_conv), .low_byte_strobe(low_byte_strobe),
        .high_byte_strobe(high_byte_strobe), .dly(dly),
        .adc_eoc(adc_eoc), .adc_data(adc_data), .cnt(pcnt));
    // Byte the converter hands out k-th
    function automatic [15:0] f(input [7:0] k);
        f = 16'(8'(k * 8'h3b + 8'h05));
    endfunction
    // Cycles between timed starts at ten cycles per microsecond
    function automatic [15:0] ivl(input [7:0] c);
        integer k;
        ivl = 16'(c[3:0] + 1) * 16'd10;
        for (k = 0; k < c[6:4]; k++)
            ivl = ivl * 16'd10;
    endfunction
    // Start edges, random delays and the hang guard
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        sc_q <= start_conv;
        if (start_conv && !sc_q) begin
            nrise <= nrise + 1;
            t1 <= t2;
            t2 <= cyc;
            dly <= 4'($random(seed));
        end
        if (cyc == 20000) begin
            errors = errors + 1;
            results;
        end
    end
    task automatic wr(input [7:0] a, input [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input [7:0] a, output [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic chk(input string nm, input [15:0] e, input [15:0] g);
        cmp_count = cmp_count + 1;
        if (g !== e) begin
            errors = errors + 1;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rc(input string nm, input [7:0] a, input [7:0] e);
        logic [7:0] d;
        rd(a, d);
        chk(nm, 16'(e), 16'(d));
    endtask
    // Routed outputs settle two edges after a write
    task automatic gap;
        repeat (2) @(posedge mclk);
        #1;
    endtask
    task results;
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        rc("sample", 8'h0c, 8'h00);
        rc("thresh", 8'h0d, 8'h1f);
        rc("status", 8'h0e, 8'h29);
        rc("route", 8'h10, 8'h00);
        rc("unmapped", 8'h11, 8'h00);
        rc("empty data", 8'h0f, 8'h00);
        // Free-running narrow capture run into overflow
        tr = 8'(4'($random(seed)));
        wr(8'h0d, tr);
        wr(8'h10, 8'h01);
        b = pcnt;
        n = nrise;
        wr(8'h0e, 8'h00);
        wait (nrise == n + 36);
        wr(8'h0e, 8'h20);
        repeat (80) @(posedge mclk);
        rc("status", 8'h0e, 8'h66);
        chk("irq a", 16'(cpu_irq_input_a), 16'h1);
        chk("irq b", 16'(cpu_irq_input_b), 16'h0);
        for (i = 0; i < 32; i++) begin
            rd(8'h0f, v);
            chk("data", f(b + 8'(i)), 16'(v));
            if (i == 0) rc("status", 8'h0e, 8'h24);
        end
        rc("status", 8'h0e, 8'h28);
        chk("irq a", 16'(cpu_irq_input_a), 16'h1);
        wr(8'h0f, 8'h5a);
        gap;
        chk("irq a", 16'(cpu_irq_input_a), 16'h0);
        // Timed two-byte slow capture routed to a port pin
        m = 8'h91 + 8'({$random(seed)} % 3);
        wr(8'h0d, 8'h85);
        wr(8'h10, 8'h2c);
        wr(8'h0c, m);
        b = pcnt;
        n = nrise;
        wr(8'h0e, 8'h10);
        wait (nrise == n + 5);
        wr(8'h0e, 8'h30);
        repeat (120) @(posedge mclk);
        chk("interval", ivl(m), 16'(t2 - t1));
        rc("status", 8'h0e, 8'h34);
        chk("ext irq", 16'(external_irq_output), 16'h20);
        wr(8'h10, 8'h6c);
        gap;
        chk("ext irq", 16'(external_irq_output), 16'h00);
        wr(8'h10, 8'h2e);
        gap;
        chk("ext irq", 16'(external_irq_output), 16'h20);
        chk("irq b", 16'(cpu_irq_input_b), 16'h1);
        for (i = 0; i < 10; i++) begin
            rd(8'h0f, v);
            chk("data", f(b + 8'(i)), 16'(v));
        end
        rc("status", 8'h0e, 8'h38);
        wr(8'h0f, 8'h00);
        gap;
        chk("ext irq", 16'(external_irq_output), 16'h00);
        chk("irq b", 16'(cpu_irq_input_b), 16'h0);
        // Untimed fast two-byte run, then the hold bit empties the FIFO
        wr(8'h0c, 8'h00);
        n = nrise;
        wr(8'h0e, 8'h00);
        wait (nrise == n + 2);
        wr(8'h0e, 8'h20);
        repeat (80) @(posedge mclk);
        rc("status", 8'h0e, 8'h20);
        wr(8'h0e, 8'h21);
        rc("status", 8'h0e, 8'h29);
        results;
    end
endmodule // tb
